// ==== common/drive_terminal_pkg.sv ====
// Purpose: Shared constants and types for the drive input terminal decoder
// Assumes: 250 MHz control clock, eight multi-function input terminals
// Notes:   Register map uses aligned 32-bit words on an 8-bit byte address
package drive_terminal_pkg;

    localparam int NUM_TERMS = 8;
    localparam int CODE_W    = 6;

    // Clock and timing
    localparam int CLK_PERIOD_NS    = 4;
    localparam int TICK_PERIOD_NS   = 1_000_000;
    localparam int MS_TICK_CYCLES   = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DEBOUNCE_NS      = 10_000;
    localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_CNT_W        = 12;

    // Terminal function codes
    localparam logic [CODE_W-1:0] FN_NONE         = 6'h00;
    localparam logic [CODE_W-1:0] FN_ACCDEC_LO    = 6'h04;
    localparam logic [CODE_W-1:0] FN_ACCDEC_HI    = 6'h05;
    localparam logic [CODE_W-1:0] FN_EXT_FAULT_NO = 6'h06;
    localparam logic [CODE_W-1:0] FN_EXT_FAULT_NC = 6'h07;
    localparam logic [CODE_W-1:0] FN_RESET        = 6'h08;
    localparam logic [CODE_W-1:0] FN_JOG_FWD      = 6'h09;
    localparam logic [CODE_W-1:0] FN_JOG_REV      = 6'h0a;
    localparam logic [CODE_W-1:0] FN_COAST_STOP   = 6'h0b;
    localparam logic [CODE_W-1:0] FN_TRIM_UP      = 6'h0c;
    localparam logic [CODE_W-1:0] FN_TRIM_DOWN    = 6'h0d;
    localparam logic [CODE_W-1:0] FN_RAMP_HOLD    = 6'h0f;
    localparam logic [CODE_W-1:0] FN_THREE_WIRE   = 6'h10;
    localparam logic [CODE_W-1:0] FN_EXT_STOP_NO  = 6'h11;
    localparam logic [CODE_W-1:0] FN_EXT_STOP_NC  = 6'h12;
    localparam logic [CODE_W-1:0] FN_DC_BRAKE     = 6'h13;
    localparam logic [CODE_W-1:0] FN_CL_DISABLE   = 6'h14;
    localparam logic [CODE_W-1:0] FN_SRC_SEL1     = 6'h16;
    localparam logic [CODE_W-1:0] FN_FORCE_CURR   = 6'h19;
    localparam logic [CODE_W-1:0] FN_FORCE_TERM   = 6'h1b;
    localparam logic [CODE_W-1:0] FN_MODE_SEL1    = 6'h1c;
    localparam logic [CODE_W-1:0] FN_CL_PRESET1   = 6'h1e;

    // Frequency sources and control modes
    localparam logic [2:0] SRC_HOLD     = 3'h0;
    localparam logic [2:0] SRC_DIGITAL1 = 3'h1;
    localparam logic [2:0] SRC_VOLTAGE  = 3'h4;
    localparam logic [2:0] SRC_CURRENT  = 3'h5;
    localparam logic [2:0] SRC_PULSE    = 3'h6;
    localparam logic [1:0] MODE_HOLD    = 2'h0;
    localparam logic [1:0] MODE_PANEL   = 2'h1;
    localparam logic [1:0] MODE_TERMINAL = 2'h2;
    localparam logic [1:0] ALT_TRIM     = 2'h2;
    localparam logic [1:0] WIRE_3W_A    = 2'h2;
    localparam logic [1:0] WIRE_3W_B    = 2'h3;
    localparam logic [7:0] EXT_FAULT_CODE = 8'h0f;

    // Register byte offsets
    localparam logic [7:0] REG_FUNC_LO    = 8'h00;
    localparam logic [7:0] REG_FUNC_HI    = 8'h04;
    localparam logic [7:0] REG_CONFIG     = 8'h08;
    localparam logic [7:0] REG_BRAKE_TIME = 8'h0c;
    localparam logic [7:0] REG_TRIM_RATE  = 8'h10;
    localparam logic [7:0] REG_STATUS     = 8'h14;
    localparam logic [7:0] REG_CONTROL    = 8'h18;
    localparam logic [7:0] REG_TRIM       = 8'h1c;

    // Config fields
    localparam int CFG_SRC_LSB   = 0;
    localparam int CFG_ALT_LSB   = 3;
    localparam int CFG_CLEN_BIT  = 5;
    localparam int CFG_CLSRC_LSB = 6;
    localparam int CFG_WIRE_LSB  = 8;
    localparam int CFG_MODE_LSB  = 10;
    localparam logic [31:0] CFG_MASK  = 32'h0000_0fff;
    localparam logic [31:0] CFG_RST   = 32'h0000_0401;
    localparam int CTL_RESET_BIT = 0;
    localparam logic [15:0] BRAKE_TIME_RST = 16'h0000;
    localparam logic [15:0] TRIM_RATE_RST  = 16'h0001;

    typedef logic [NUM_TERMS-1:0][CODE_W-1:0] term_codes_t;

    typedef enum logic [1:0] {
        FLT_CLEAR   = 2'b01,
        FLT_LATCHED = 2'b10
    } fault_state_e;

    typedef enum logic [1:0] {
        STP_IDLE = 2'b01,
        STP_HELD = 2'b10
    } stop_state_e;

    typedef struct packed {
        logic [1:0]  accdec_sel;
        logic        fault;
        logic [7:0]  fault_code;
        logic        jog_fwd;
        logic        jog_rev;
        logic        coast_stop;
        logic        ramp_hold;
        logic        three_wire_run;
        logic        ext_stop;
        logic        catch_spin;
        logic        dc_brake;
        logic        closed_loop_active;
        logic [2:0]  freq_source;
        logic [1:0]  control_mode;
        logic [2:0]  cl_preset;
        logic [15:0] freq_trim;
    } drive_cmd_s;

endpackage : drive_terminal_pkg

// ==== design/terminal_debounce.sv ====
// Purpose: Two-stage synchroniser and per-terminal debounce filter
// Assumes: Level must stay unchanged DEBOUNCE_CYCLES cycles to be accepted
// Notes:   First stage feeds only the second stage
module terminal_debounce
    import drive_terminal_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [NUM_TERMS-1:0] raw_i,
    output logic      [NUM_TERMS-1:0] level_o
);

    localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEBOUNCE_CYCLES - 1);

    typedef struct packed {
        logic [NUM_TERMS-1:0]                meta;
        logic [NUM_TERMS-1:0]                sync;
        logic [NUM_TERMS-1:0]                stable;
        logic [NUM_TERMS-1:0][DEB_CNT_W-1:0] cnt;
    } deb_state_s;

    deb_state_s r_reg;
    deb_state_s r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.meta = raw_i;
        r_next.sync = r_reg.meta;
        for (int i = 0; i < NUM_TERMS; i++) begin
            if (r_reg.sync[i] == r_reg.stable[i]) begin
                r_next.cnt[i] = '0;
            end else if (r_reg.cnt[i] == DEB_LAST) begin
                r_next.cnt[i]    = '0;
                r_next.stable[i] = r_reg.sync[i];
            end else begin
                r_next.cnt[i] = r_reg.cnt[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign level_o = r_reg.stable;

endmodule : terminal_debounce

// ==== design/drive_input_terminal_decoder.sv ====
// Purpose: Decodes the multi-function input terminals into drive commands
// Assumes: Terminal inputs are contact levels, high when the contact is closed
// Notes:   Reads return data the cycle after the read strobe; no wait states
// Operation
// RL1: Two select inputs choose time set 1-4
// RL2: External fault entry latches fault, shows code
// RL3: Fault input normally-open or normally-closed by code
// RL4: Reset terminal clears fault like panel key
// RL5: Jog terminals start jog in matching direction
// RL6: Coast-stop terminal triggers free-run stop
// RL7: Up/down trim reference at rate when enabled
// RL8: Ramp hold freezes speed except stop
// RL9: Ramp hold ignored during decelerate-to-stop
// RL10: Code 16 gives three-wire run input
// RL11: External stop while running holds zero output
// RL12: Stop removal restarts with catch-on-the-fly
// RL13: External stop never raises fault
// RL14: Braking lasts longer of time or terminal
// RL15: Closed-loop disable works only when enabled
// RL16: Three source-select terminals map to sources
// RL17: Latest of terminals or parameter wins
// RL18: Force-current terminal overrides source, then restores
// RL19: Force-terminal terminal overrides control mode
// RL20: Two mode-select terminals map to modes
// RL21: Closed-loop preset index, zero means parameter
// RL22: Unassigned codes inert; inputs synchronised, debounced
// RL23: Field must hold selections until debounced
module drive_input_terminal_decoder
    import drive_terminal_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
)(
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [NUM_TERMS-1:0] terminal_i,
    input  wire logic                 running_i,
    input  wire logic                 decel_stop_i,
    input  wire logic                 stop_cmd_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [31:0]          wr_data_i,
    input  wire logic                 wr_en_i,
    input  wire logic                 rd_en_i,
    output logic      [31:0]          rd_data_o,
    output drive_cmd_s                drive_cmd_o
);

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    typedef struct packed {
        term_codes_t  codes;
        logic [31:0]  cfg;
        logic [15:0]  brake_time;
        logic [15:0]  trim_rate;
        logic [31:0]  rd_data;
        fault_state_e fault_st;
        stop_state_e  stop_st;
        logic         fault_in_d;
        logic         reset_in_d;
        logic         brake_in_d;
        logic [2:0]   src_sel_d;
        logic [1:0]   mode_sel_d;
        logic [2:0]   base_src;
        logic [1:0]   base_mode;
        logic [31:0]  tick_cnt;
        logic [15:0]  brake_cnt;
        logic [15:0]  trim_cnt;
        drive_cmd_s   cmd;
    } dec_state_s;

    dec_state_s           r_reg;
    dec_state_s           r_next;
    logic [NUM_TERMS-1:0] lvl;
    logic                 tick;
    logic                 fault_in;
    logic                 reset_in;
    logic                 brake_in;
    logic                 stop_in;
    logic                 hold;
    logic                 trim_en;
    logic                 up_in;
    logic                 down_in;
    logic                 clear_req;
    logic [2:0]           src_sel;
    logic [1:0]           mode_sel;
    logic [1:0]           wire_mode;

    terminal_debounce u_debounce (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .raw_i     (terminal_i),
        .level_o   (lvl)
    );

    // True when any terminal carrying this code is active at this level
    function automatic logic any_on(
        input logic [NUM_TERMS-1:0] lv,
        input term_codes_t          codes,
        input logic [CODE_W-1:0]    fn
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            hit = hit | (lv[i] & (codes[i] == fn) & (fn != FN_NONE)); // RL22
        end
        return hit;
    endfunction : any_on

    // Gathers a binary select word from consecutive function codes
    function automatic logic [2:0] sel_word(
        input logic [NUM_TERMS-1:0] lv,
        input term_codes_t          codes,
        input logic [CODE_W-1:0]    first,
        input int                   bits
    );
        logic [2:0] w;
        w = 3'h0;
        for (int k = 0; k < bits; k++) begin
            w[k] = any_on(lv, codes, CODE_W'(first + CODE_W'(k)));
        end
        return w;
    endfunction : sel_word

    // Source word from terminals; both pulse codes collapse to one source
    function automatic logic [2:0] map_src(input logic [2:0] sel);
        return (sel == 3'h7) ? SRC_PULSE : sel; // RL16
    endfunction : map_src

    always_comb begin
        r_next    = r_reg;
        tick      = (r_reg.tick_cnt == TICK_LAST);
        fault_in  = any_on(lvl, r_reg.codes, FN_EXT_FAULT_NO)
                  | any_on(~lvl, r_reg.codes, FN_EXT_FAULT_NC); // RL3
        stop_in   = any_on(lvl, r_reg.codes, FN_EXT_STOP_NO)
                  | any_on(~lvl, r_reg.codes, FN_EXT_STOP_NC); // RL11
        reset_in  = any_on(lvl, r_reg.codes, FN_RESET);
        brake_in  = any_on(lvl, r_reg.codes, FN_DC_BRAKE);
        up_in     = any_on(lvl, r_reg.codes, FN_TRIM_UP);
        down_in   = any_on(lvl, r_reg.codes, FN_TRIM_DOWN);
        src_sel   = sel_word(lvl, r_reg.codes, FN_SRC_SEL1, 3);
        mode_sel  = 2'(sel_word(lvl, r_reg.codes, FN_MODE_SEL1, 2));
        wire_mode = r_reg.cfg[CFG_WIRE_LSB +: 2];
        // Stop commands and a normal deceleration both override the hold
        hold      = any_on(lvl, r_reg.codes, FN_RAMP_HOLD)
                  & ~stop_cmd_i // RL8
                  & ~decel_stop_i; // RL9
        trim_en   = (r_reg.cmd.freq_source == SRC_DIGITAL1)
                  | (r_reg.cfg[CFG_ALT_LSB +: 2] == ALT_TRIM); // RL7
        clear_req = (reset_in & ~r_reg.reset_in_d); // RL4

        r_next.fault_in_d = fault_in;
        r_next.reset_in_d = reset_in;
        r_next.brake_in_d = brake_in;
        r_next.src_sel_d  = src_sel;
        r_next.mode_sel_d = mode_sel;
        r_next.tick_cnt   = tick ? 32'h0000_0000 : r_reg.tick_cnt + 32'h0000_0001;

        // Selection changes from the terminals; the all-off code keeps the current choice
        if (src_sel != r_reg.src_sel_d && src_sel != SRC_HOLD) begin
            r_next.base_src = map_src(src_sel); // RL17
        end
        if (mode_sel != r_reg.mode_sel_d && mode_sel != MODE_HOLD) begin
            r_next.base_mode = mode_sel; // RL20
        end

        // Register writes; a parameter write in the same cycle as a terminal change wins
        if (wr_en_i) begin
            case (addr_i)
                REG_FUNC_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        r_next.codes[i] = wr_data_i[8*i +: CODE_W];
                    end
                end
                REG_FUNC_HI: begin
                    for (int i = 0; i < 4; i++) begin
                        r_next.codes[i+4] = wr_data_i[8*i +: CODE_W];
                    end
                end
                REG_CONFIG: begin
                    r_next.cfg       = wr_data_i & CFG_MASK;
                    r_next.base_src  = wr_data_i[CFG_SRC_LSB +: 3]; // RL17
                    r_next.base_mode = wr_data_i[CFG_MODE_LSB +: 2];
                end
                REG_BRAKE_TIME: r_next.brake_time = wr_data_i[15:0];
                REG_TRIM_RATE:  r_next.trim_rate  = wr_data_i[15:0];
                REG_CONTROL:    clear_req = clear_req | wr_data_i[CTL_RESET_BIT]; // RL4
                default: ;
            endcase
        end

        // Fault latch: a new fault in the clearing cycle keeps the latch set
        unique case (r_reg.fault_st)
            FLT_CLEAR: begin
                if (fault_in && !r_reg.fault_in_d) begin
                    r_next.fault_st = FLT_LATCHED; // RL2
                end
            end
            FLT_LATCHED: begin
                if (clear_req && !(fault_in && !r_reg.fault_in_d)) begin
                    r_next.fault_st = FLT_CLEAR; // RL4
                end
            end
        endcase

        // External stop only gates the output; it never touches the fault latch
        r_next.cmd.catch_spin = 1'b0;
        unique case (r_reg.stop_st)
            STP_IDLE: begin
                if (stop_in && running_i) begin
                    r_next.stop_st = STP_HELD; // RL11
                end
            end
            STP_HELD: begin
                if (!stop_in) begin
                    r_next.stop_st        = STP_IDLE;
                    r_next.cmd.catch_spin = 1'b1; // RL12
                end
            end
        endcase

        // Brake timer starts at the terminal edge and runs alongside the level
        if (brake_in && !r_reg.brake_in_d) begin
            r_next.brake_cnt = r_reg.brake_time; // RL14
        end else if (tick && r_reg.brake_cnt != 16'h0000) begin
            r_next.brake_cnt = r_reg.brake_cnt - 16'h0001;
        end

        // Trim steps once per trim_rate ticks; a held ramp freezes the reference
        if (tick && trim_en && !hold && (up_in ^ down_in)) begin
            if (r_reg.trim_cnt + 16'h0001 >= r_reg.trim_rate) begin
                r_next.trim_cnt = 16'h0000;
                if (up_in && r_reg.cmd.freq_trim != 16'hffff) begin
                    r_next.cmd.freq_trim = r_reg.cmd.freq_trim + 16'h0001; // RL7
                end else if (down_in && r_reg.cmd.freq_trim != 16'h0000) begin
                    r_next.cmd.freq_trim = r_reg.cmd.freq_trim - 16'h0001; // RL7
                end
            end else begin
                r_next.trim_cnt = r_reg.trim_cnt + 16'h0001;
            end
        end else if (!(up_in ^ down_in)) begin
            r_next.trim_cnt = 16'h0000;
        end

        r_next.cmd.accdec_sel = 2'(sel_word(lvl, r_reg.codes, FN_ACCDEC_LO, 2)); // RL1
        r_next.cmd.fault      = (r_next.fault_st == FLT_LATCHED); // RL2
        r_next.cmd.fault_code = (r_next.fault_st == FLT_LATCHED) ? EXT_FAULT_CODE : 8'h00;
        r_next.cmd.jog_fwd    = any_on(lvl, r_reg.codes, FN_JOG_FWD)
                              & ~any_on(lvl, r_reg.codes, FN_JOG_REV); // RL5
        r_next.cmd.jog_rev    = any_on(lvl, r_reg.codes, FN_JOG_REV)
                              & ~any_on(lvl, r_reg.codes, FN_JOG_FWD); // RL5
        r_next.cmd.coast_stop = any_on(lvl, r_reg.codes, FN_COAST_STOP); // RL6
        r_next.cmd.ramp_hold  = hold; // RL8
        r_next.cmd.three_wire_run = any_on(lvl, r_reg.codes, FN_THREE_WIRE)
                              & ((wire_mode == WIRE_3W_A) | (wire_mode == WIRE_3W_B)); // RL10
        r_next.cmd.ext_stop   = (r_next.stop_st == STP_HELD); // RL13
        r_next.cmd.dc_brake   = brake_in | (r_next.brake_cnt != 16'h0000); // RL14
        r_next.cmd.closed_loop_active = r_reg.cfg[CFG_CLEN_BIT]
                              & ~any_on(lvl, r_reg.codes, FN_CL_DISABLE); // RL15
        // Overrides sit on top of the base choice, so release restores it
        r_next.cmd.freq_source = any_on(lvl, r_reg.codes, FN_FORCE_CURR)
                              ? SRC_CURRENT : r_next.base_src; // RL18
        r_next.cmd.control_mode = any_on(lvl, r_reg.codes, FN_FORCE_TERM)
                              ? MODE_TERMINAL : r_next.base_mode; // RL19
        r_next.cmd.cl_preset  = sel_word(lvl, r_reg.codes, FN_CL_PRESET1, 3); // RL21

        r_next.rd_data = 32'h0000_0000;
        if (rd_en_i) begin
            case (addr_i)
                REG_FUNC_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        r_next.rd_data[8*i +: CODE_W] = r_reg.codes[i];
                    end
                end
                REG_FUNC_HI: begin
                    for (int i = 0; i < 4; i++) begin
                        r_next.rd_data[8*i +: CODE_W] = r_reg.codes[i+4];
                    end
                end
                REG_CONFIG:     r_next.rd_data = r_reg.cfg;
                REG_BRAKE_TIME: r_next.rd_data = {16'h0000, r_reg.brake_time};
                REG_TRIM_RATE:  r_next.rd_data = {16'h0000, r_reg.trim_rate};
                REG_STATUS: begin
                    r_next.rd_data = {lvl, 5'h00, r_reg.cmd.cl_preset,
                                      r_reg.cmd.control_mode, r_reg.cmd.freq_source,
                                      r_reg.cmd.closed_loop_active, r_reg.cmd.dc_brake,
                                      r_reg.cmd.ext_stop, r_reg.cmd.three_wire_run,
                                      r_reg.cmd.ramp_hold, r_reg.cmd.coast_stop,
                                      r_reg.cmd.jog_rev, r_reg.cmd.jog_fwd,
                                      r_reg.cmd.fault, r_reg.cmd.accdec_sel};
                end
                REG_TRIM:       r_next.rd_data = {16'h0000, r_reg.cmd.freq_trim};
                default:        r_next.rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r_reg                  <= '0;
            r_reg.cfg              <= CFG_RST;
            r_reg.brake_time       <= BRAKE_TIME_RST;
            r_reg.trim_rate        <= TRIM_RATE_RST;
            r_reg.fault_st         <= FLT_CLEAR;
            r_reg.stop_st          <= STP_IDLE;
            r_reg.base_src         <= SRC_DIGITAL1;
            r_reg.base_mode        <= MODE_PANEL;
            r_reg.cmd.freq_source  <= SRC_DIGITAL1;
            r_reg.cmd.control_mode <= MODE_PANEL;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rd_data_o   = r_reg.rd_data;
    assign drive_cmd_o = r_reg.cmd;

endmodule : drive_input_terminal_decoder

// ==== bench/field_contacts.sv ====
// Purpose: Field contact model feeding the terminal inputs
// Assumes: Contacts chatter briefly after each change when asked to
// Notes:   Chatter stays far shorter than the debounce window
module field_contacts
    import drive_terminal_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic [NUM_TERMS-1:0] want_i,
    input  wire logic                 bounce_i,
    output logic      [NUM_TERMS-1:0] contact_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_TERMS-1:0] held_reg    = '0;
    logic [3:0]           chatter_reg = 4'h0;
    always @(posedge ref_clk_i) begin
        if (want_i != held_reg) chatter_reg <= bounce_i ? 4'h8 : 4'h0;
        else if (chatter_reg != 4'h0) chatter_reg <= chatter_reg - 4'h1;
        held_reg <= want_i;
    end
    // Selection only holds steady once the chatter has died out
    assign contact_o = chatter_reg[0] ? ~held_reg : held_reg;
endmodule : field_contacts

// ==== bench/drive_input_terminal_decoder_asserts.sv ====
// Purpose: Port-level checks of the terminal decoder
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every decoder instance
module drive_input_terminal_decoder_asserts
    import drive_terminal_pkg::*;
#(
    parameter int TICK_CYCLES = 10
)(
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        stop_cmd_i,
    input wire logic        decel_stop_i,
    input wire logic        rd_en_i,
    input wire logic [31:0] rd_data_o,
    input wire drive_cmd_s  drive_cmd_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    rd_idle_zero_a: assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    fault_code_a: assert property (drive_cmd_o.fault ? drive_cmd_o.fault_code == EXT_FAULT_CODE
        : drive_cmd_o.fault_code == 8'h00) else $error("fault code mismatch");
    jog_excl_a: assert property (!(drive_cmd_o.jog_fwd && drive_cmd_o.jog_rev))
        else $error("both jog directions active");
    catch_pulse_a: assert property (drive_cmd_o.catch_spin |=> !drive_cmd_o.catch_spin)
        else $error("catch pulse too long");
    catch_cause_a: assert property ($rose(drive_cmd_o.catch_spin) |-> $fell(drive_cmd_o.ext_stop))
        else $error("catch pulse without stop release");
    stop_no_fault_a: assert property ($rose(drive_cmd_o.ext_stop) |-> !$rose(drive_cmd_o.fault))
        else $error("external stop raised fault");
    hold_masked_a: assert property ((stop_cmd_i || decel_stop_i)[*2] |-> !drive_cmd_o.ramp_hold)
        else $error("ramp hold active during stop");
    trim_step_a: assert property ($changed(drive_cmd_o.freq_trim) |->
        drive_cmd_o.freq_trim == $past(drive_cmd_o.freq_trim) + 16'h0001 ||
        drive_cmd_o.freq_trim == $past(drive_cmd_o.freq_trim) - 16'h0001)
        else $error("trim moved more than one step");
    src_legal_a: assert property (drive_cmd_o.freq_source inside {[3'h1:3'h6]} &&
        drive_cmd_o.control_mode != MODE_HOLD) else $error("illegal source or mode");
endmodule : drive_input_terminal_decoder_asserts

bind drive_input_terminal_decoder drive_input_terminal_decoder_asserts #(
    .TICK_CYCLES(TICK_CYCLES)
) chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .stop_cmd_i(stop_cmd_i),
    .decel_stop_i(decel_stop_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .drive_cmd_o(drive_cmd_o));

// ==== bench/drive_input_terminal_decoder_test.sv ====
// Purpose: Self-checking bench for the terminal decoder
// Assumes: 250 MHz clock, contacts supplied by the field model
// Notes:   Fixed settle wait covers sync plus debounce
module drive_input_terminal_decoder_test
    import drive_terminal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] t; logic [1:0] acc; logic [2:0] src; logic [1:0] md;} row_s;
    localparam row_s ROWS [7] = '{'{8'h00, 2'h0, 3'h1, 2'h1}, '{8'h05, 2'h1, 3'h1, 2'h1},
        '{8'h2a, 2'h2, 3'h2, 2'h1}, '{8'h5f, 2'h3, 3'h6, 2'h2}, '{8'h71, 2'h1, 3'h4, 2'h3},
        '{8'h14, 2'h0, 3'h5, 2'h3}, '{8'h00, 2'h0, 3'h5, 2'h3}};
    logic       ref_clk, rst_n, running, decel_stop, stop_cmd, wr_en, rd_en, bounce;
    logic [7:0] addr, want, terms;
    logic [31:0] wr_data, rd_data;
    drive_cmd_s cmd;
    int         miscompares = 0;
    int         cmp_count = 0;
    field_contacts field (.ref_clk_i(ref_clk), .want_i(want), .bounce_i(bounce), .contact_o(terms));
    drive_input_terminal_decoder #(.TICK_CYCLES(10)) DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .terminal_i(terms), .running_i(running), .decel_stop_i(decel_stop),
        .stop_cmd_i(stop_cmd), .addr_i(addr), .wr_data_i(wr_data), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .rd_data_o(rd_data), .drive_cmd_o(cmd));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) {wr_en, addr, wr_data} <= {1'b1, a, d};
        @(posedge ref_clk) wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk) {rd_en, addr} <= {1'b1, a};
        @(posedge ref_clk) rd_en <= 1'b0;
        #1 chk(rd_data & m, e);
    endtask : rd
    task automatic drive(input logic [7:0] t);
        @(posedge ref_clk) want <= t;
        repeat (2600) @(posedge ref_clk);
        #1;
    endtask : drive
    initial begin
        {rst_n, running, decel_stop, stop_cmd, wr_en, rd_en, bounce} = '0;
        {addr, want, wr_data} = '0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_CONFIG, 32'hffff_ffff, CFG_RST);
        rd(REG_BRAKE_TIME, 32'hffff_ffff, {16'h0000, BRAKE_TIME_RST});
        rd(REG_TRIM_RATE, 32'hffff_ffff, {16'h0000, TRIM_RATE_RST});
        // X1..X4: time set lo/hi, source sel 1/2; X5..X8: source sel 3, mode 1/2, fault NO
        wr(REG_FUNC_LO, 32'h1716_0504);
        wr(REG_FUNC_HI, 32'h061d_1c18);
        {bounce, stop_cmd, decel_stop} <= 3'b111;
        foreach (ROWS[i]) begin
            drive(ROWS[i].t);
            chk({cmd.accdec_sel, cmd.freq_source, cmd.control_mode},
                {ROWS[i].acc, ROWS[i].src, ROWS[i].md});
        end
        {bounce, stop_cmd, decel_stop} <= 3'b000;
        drive(8'h80);
        chk({cmd.fault, cmd.fault_code}, {1'b1, EXT_FAULT_CODE});
        rd(REG_STATUS, 32'hff00_0004, 32'h8000_0004);
        wr(REG_CONTROL, 32'h0000_0001);
        @(posedge ref_clk) #1 chk(cmd.fault, 1'b0);
        wr(REG_FUNC_HI, 32'h071d_1c18);
        drive(8'h00);
        chk(cmd.fault, 1'b1);
        wr(REG_CONTROL, 32'h0000_0001);
        wr(REG_FUNC_HI, 32'h111d_1c18);
        running <= 1'b1;
        drive(8'h80);
        chk({cmd.ext_stop, cmd.fault}, 2'b10);
        @(posedge ref_clk) want <= 8'h00;
        for (int n = 0; n < 3000 && cmd.catch_spin !== 1'b1; n++) @(posedge ref_clk) #1;
        chk({cmd.catch_spin, cmd.ext_stop, cmd.fault}, 3'b100);
        @(posedge ref_clk) #1 chk(cmd.catch_spin, 1'b0);
        wr(REG_CONFIG, 32'hffff_f426);
        rd(REG_CONFIG, 32'hffff_ffff, 32'h0000_0426);
        chk({cmd.freq_source, cmd.control_mode}, {3'h6, 2'h1});
        // X1..X4: jog fwd, coast, brake, loop off; X5..X8: force current, force terminal, preset, hold
        wr(REG_FUNC_LO, 32'h1413_0b09);
        wr(REG_FUNC_HI, 32'h0f1e_1b19);
        drive(8'hff);
        chk({cmd.jog_fwd, cmd.coast_stop,
            cmd.dc_brake, cmd.ramp_hold, cmd.closed_loop_active, cmd.freq_source,
            cmd.control_mode, cmd.cl_preset}, 32'h0000_1eb1);
        drive(8'h00);
        chk({cmd.jog_fwd, cmd.coast_stop,
            cmd.dc_brake, cmd.ramp_hold, cmd.closed_loop_active, cmd.freq_source,
            cmd.control_mode, cmd.cl_preset}, 32'h0000_01c8);
        rd(8'h20, 32'hffff_ffff, 32'h0000_0000);
        rd(REG_CONTROL, 32'hffff_ffff, 32'h0000_0000);
        end_sim();
    end
endmodule : drive_input_terminal_decoder_test
